// ==== tcn_pkg.sv ====
package tcn_pkg;

    // -----------------------------------------------------------------
    // bus geometry
    // -----------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [5:0] CNT_LO_IDX = 6'h0e;
    localparam logic [5:0] CNT_HI_IDX = 6'h0f;
    localparam logic [5:0] CTRL_IDX   = 6'h10;
    localparam logic [5:0] FLAG_IDX   = 6'h11;
    localparam logic [5:0] IRQEN_IDX  = 6'h12;

    // control register fields
    localparam int unsigned CTRL_W    = 6;
    localparam int unsigned RUN_BIT   = 0;
    localparam int unsigned CS_BIT    = 1;
    localparam int unsigned SYNCB_BIT = 2;
    localparam int unsigned OSCEN_BIT = 3;
    localparam int unsigned PS_LSB    = 4;
    localparam int unsigned PS_W      = 2;
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

    // counter geometry and reset values
    localparam int unsigned CNT_W      = 16;
    localparam int unsigned PRE_W      = 3;
    localparam logic [CNT_W-1:0] CNT_MAX  = 16'hffff;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [PRE_W-1:0] PRE_ZERO = 3'h0;

    // compare unit mode that fires the special event trigger
    localparam logic [3:0] SPECIAL_EVT_MODE = 4'hb;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // pin synchroniser: bit 0 external count pin, bit 1 oscillator input
    localparam int unsigned PIN_W   = 2;
    localparam int unsigned PIN_EXT = 0;
    localparam int unsigned PIN_OSC = 1;

    typedef enum logic
    {
        WR_IDLE = 1'b0,
        WR_RESP = 1'b1
    } tcn_wr_state_t;

    typedef enum logic [1:0]
    {
        MODE_TIMER = 2'b00,
        MODE_SYNC  = 2'b01,
        MODE_ASYNC = 2'b11
    } tcn_mode_t;

endpackage : tcn_pkg

// ==== tcn_pin_if.sv ====
`timescale 1ns/10ps
`default_nettype none

// raw pin levels in, synchronised levels out
interface tcn_pin_if;
    import tcn_pkg::*;
    logic [PIN_W-1:0] raw;
    logic [PIN_W-1:0] sync;

    modport syncer (input raw, output sync);
    modport user   (output raw, input sync);
endinterface : tcn_pin_if

`default_nettype wire

// ==== tcn_pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none

module tcn_pin_sync
    import tcn_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    input  wire logic   ce_i,
    tcn_pin_if.syncer   pins
);

    logic [PIN_W-1:0] meta_q;
    logic [PIN_W-1:0] sync_q;

    // two stages; first stage feeds only the second
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else if (ce_i)
        begin
            meta_q <= pins.raw;
            sync_q <= meta_q;
        end
    end

    assign pins.sync = sync_q;

endmodule // tcn_pin_sync

`default_nettype wire

// ==== tcn_timer.sv ====
//
// Overview of operation
// - source select clear: count internal clock; sync bypass ignored
// - source select set: count rising edges of oscillator or external pin
// - sync bypass clear: also synchronise prescaler output; its input pins are synchronised in every mode
// - prescaler is a ripple counter driven by the selected count clock
// - synchronised counter mode in sleep: count holds, prescaler still counts
// - sync bypass set: counts in sleep; overflow can wake the processor
// - asynchronous counter mode: count not offered as capture/compare base
// - byte reads of the running count always return a clean value
// - oscillator enable runs the crystal oscillator, also during sleep
// - special event trigger from either compare unit clears the count
// - special event clear never sets the overflow flag
// - special event clear guaranteed only in timer or synchronised mode
// - count write in same cycle as special event clear wins
// - compare value pair acts as period through the special event clear
// - count bytes survive every reset; only special event clears them
// - power-on reset clears control: counter stopped, prescale 1:1
// - any write to either count byte clears the prescaler
// - count wraps ffff to 0000, sets overflow flag; irq if enabled
// - prescale select 00,01,10,11 divides by 1,2,4,8
// - counter advances only on ticks taken while run enable is set; a synchronised tick can land the cycle after it clears
//
`timescale 1ns/10ps
`default_nettype none

module tcn_timer
    import tcn_pkg::*;
(
    input  wire logic                        CLK_I,
    input  wire logic                        SYS_RST_I,
    input  wire logic                        WARM_RST_I,
    input  wire logic                        CE_I,
    input  wire logic                        SLEEP_I,
    input  wire logic                        EXT_CNT_I,
    input  wire logic                        OSC_IN_I,
    output var  logic                        OSC_OUT_O,
    output var  logic                        OSC_OUT_OE_O,
    input  wire logic [3:0]                  CMP1_MODE_I,
    input  wire logic                        CMP1_TRIG_I,
    input  wire logic [3:0]                  CMP2_MODE_I,
    input  wire logic                        CMP2_TRIG_I,
    output var  logic [tcn_pkg::CNT_W-1:0]   COUNT_O,
    output var  logic                        COUNT_BASE_VALID_O,
    output var  logic                        OVF_IRQ_O,
    output var  logic                        WAKE_O,
    input  wire logic [tcn_pkg::ADDR_W-1:0]  S_AXI_AWADDR,
    input  wire logic                        S_AXI_AWVALID,
    output var  logic                        S_AXI_AWREADY,
    input  wire logic [tcn_pkg::DATA_W-1:0]  S_AXI_WDATA,
    input  wire logic [3:0]                  S_AXI_WSTRB,
    input  wire logic                        S_AXI_WVALID,
    output var  logic                        S_AXI_WREADY,
    output var  logic [1:0]                  S_AXI_BRESP,
    output var  logic                        S_AXI_BVALID,
    input  wire logic                        S_AXI_BREADY,
    input  wire logic [tcn_pkg::ADDR_W-1:0]  S_AXI_ARADDR,
    input  wire logic                        S_AXI_ARVALID,
    output var  logic                        S_AXI_ARREADY,
    output var  logic [tcn_pkg::DATA_W-1:0]  S_AXI_RDATA,
    output var  logic [1:0]                  S_AXI_RRESP,
    output var  logic                        S_AXI_RVALID,
    input  wire logic                        S_AXI_RREADY
);
    import tcn_pkg::*;

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic [CTRL_W-1:0]  ctrl_q;
    logic [CNT_W-1:0]   count_q;
    logic               known_q;
    logic [PRE_W-1:0]   pre_q;
    logic               sync_tick_q;
    logic               src_prev_q;
    logic               armed_q;
    logic               flag_q;
    logic               irq_en_q;
    logic               osc_out_q;
    logic [CNT_W-1:0]   base_q;
    logic               base_valid_q;
    tcn_wr_state_t      wr_state_q;
    logic               aw_got_q;
    logic               w_got_q;
    logic [5:0]         awidx_q;
    logic [7:0]         wbyte_q;
    logic               wlane_q;
    logic               rvalid_q;
    logic [DATA_W-1:0]  rdata_q;
    logic [1:0]         rresp_q;

    tcn_pin_if pin_bus ();

    tcn_pin_sync u_pin_sync
    (
        .clk_i (CLK_I),
        .rst_i (SYS_RST_I),
        .ce_i  (CE_I),
        .pins  (pin_bus.syncer)
    );

    assign pin_bus.raw[PIN_EXT] = EXT_CNT_I;
    assign pin_bus.raw[PIN_OSC] = OSC_IN_I;

    // -----------------------------------------------------------------
    // control decode
    // -----------------------------------------------------------------
    wire             run_en   = ctrl_q[RUN_BIT];
    wire             ext_sel  = ctrl_q[CS_BIT];
    wire             sync_byp = ctrl_q[SYNCB_BIT];
    wire             osc_en   = ctrl_q[OSCEN_BIT];
    wire [PS_W-1:0]  ps_sel   = ctrl_q[PS_LSB +: PS_W];

    // bypass only matters with the external source selected
    wire tcn_mode_t mode = !ext_sel  ? MODE_TIMER :
                           !sync_byp ? MODE_SYNC  : MODE_ASYNC;

    // -----------------------------------------------------------------
    // count clock selection and prescaler
    // -----------------------------------------------------------------
    // oscillator input replaces the pin while the oscillator runs
    wire src_lvl  = osc_en ? pin_bus.sync[PIN_OSC]
                           : pin_bus.sync[PIN_EXT];
    wire src_rise = src_lvl && !src_prev_q && armed_q;
    // internal clock stops in sleep; external edges do not
    wire src_tick = run_en && (ext_sel ? src_rise : !SLEEP_I);

    // divide mask: 000, 001, 011, 111 for 1:1 .. 1:8
    wire [PRE_W-1:0] pre_mask = PRE_W'((4'h1 << ps_sel) - 4'h1);
    wire pre_out = src_tick && ((pre_q & pre_mask) == pre_mask);

    // synchroniser stage halts in sleep, prescaler keeps going
    wire adv_sync  = sync_tick_q && !SLEEP_I;
    wire cnt_adv   = (mode == MODE_TIMER) ? pre_out :
                     (mode == MODE_SYNC)  ? adv_sync :
                                            pre_out;

    // -----------------------------------------------------------------
    // special event trigger
    // -----------------------------------------------------------------
    wire evt1 = CMP1_TRIG_I && (CMP1_MODE_I == SPECIAL_EVT_MODE);
    wire evt2 = CMP2_TRIG_I && (CMP2_MODE_I == SPECIAL_EVT_MODE);
    // asynchronous mode drops the clear rather than racing it
    wire evt_clr = (evt1 || evt2) && (mode != MODE_ASYNC);

    // -----------------------------------------------------------------
    // bus write path
    // -----------------------------------------------------------------
    wire aw_hs   = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_hs    = S_AXI_WVALID && S_AXI_WREADY;
    wire aw_have = aw_got_q || aw_hs;
    wire w_have  = w_got_q || w_hs;
    wire do_wr   = (wr_state_q == WR_IDLE) && aw_have && w_have;

    wire [5:0] wr_idx  = aw_got_q ? awidx_q : S_AXI_AWADDR[ADDR_W-1:2];
    wire [7:0] wr_byte = w_got_q ? wbyte_q : S_AXI_WDATA[7:0];
    wire       wr_lane = w_got_q ? wlane_q : S_AXI_WSTRB[0];
    wire       wr_en   = do_wr && wr_lane;

    wire wr_lo    = wr_en && (wr_idx == CNT_LO_IDX);
    wire wr_hi    = wr_en && (wr_idx == CNT_HI_IDX);
    wire wr_ctrl  = wr_en && (wr_idx == CTRL_IDX);
    wire wr_flag  = wr_en && (wr_idx == FLAG_IDX);
    wire wr_irqen = wr_en && (wr_idx == IRQEN_IDX);
    wire wr_cnt   = wr_lo || wr_hi;

    wire wr_mapped = (wr_idx == CNT_LO_IDX) || (wr_idx == CNT_HI_IDX) ||
                     (wr_idx == CTRL_IDX)   || (wr_idx == FLAG_IDX)   ||
                     (wr_idx == IRQEN_IDX);

    assign S_AXI_AWREADY = (wr_state_q == WR_IDLE) && !aw_got_q;
    assign S_AXI_WREADY  = (wr_state_q == WR_IDLE) && !w_got_q;
    assign S_AXI_BVALID  = (wr_state_q == WR_RESP);

    // -----------------------------------------------------------------
    // counter next value: write beats clear beats increment
    // -----------------------------------------------------------------
    // a write or a clear in the same cycle takes the place of the wrap
    wire wrap = cnt_adv && (count_q == CNT_MAX) && !wr_cnt && !evt_clr;
    logic [CNT_W-1:0] count_d;

    always_comb
    begin
        count_d = count_q;
        if (wr_cnt)
        begin
            if (wr_lo)
                count_d[7:0] = wr_byte;
            if (wr_hi)
                count_d[15:8] = wr_byte;
        end
        else if (evt_clr)
            count_d = CNT_ZERO;
        else if (cnt_adv)
            count_d = count_q + 16'h0001;
    end

    // no reset at all: contents survive every reset
    always_ff @(posedge CLK_I)
    begin
        if (CE_I)
            count_q <= count_d;
    end

    // marks the count as defined once written or cleared; no reset, so
    // like the count it survives every reset and only power-up leaves it open
    always_ff @(posedge CLK_I)
    begin
        if (CE_I && (wr_cnt || evt_clr))
            known_q <= 1'b1;
    end

    // -----------------------------------------------------------------
    // prescaler, edge detect, synchroniser stage
    // -----------------------------------------------------------------
    // the ripple chain is modelled as a count of source ticks
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            pre_q       <= PRE_ZERO;
            sync_tick_q <= 1'b0;
            src_prev_q  <= 1'b0;
            armed_q     <= 1'b0;
        end
        else if (CE_I)
        begin
            if (WARM_RST_I || wr_cnt)
                pre_q <= PRE_ZERO;
            else if (src_tick)
                pre_q <= pre_q + 3'h1;
            sync_tick_q <= pre_out && !SLEEP_I;
            src_prev_q  <= src_lvl;
            // first counted edge must follow a falling edge
            if (!ext_sel || !run_en)
                armed_q <= 1'b0;
            else if (!src_lvl && src_prev_q)
                armed_q <= 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // control, flag, enable, oscillator, time base
    // -----------------------------------------------------------------
    // only power-on reset touches control; warm reset leaves it
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            ctrl_q       <= CTRL_RST;
            flag_q       <= 1'b0;
            irq_en_q     <= 1'b0;
            osc_out_q    <= 1'b0;
            base_q       <= CNT_ZERO;
            base_valid_q <= 1'b0;
        end
        else if (CE_I)
        begin
            if (wr_ctrl)
                ctrl_q <= wr_byte[CTRL_W-1:0];
            // wrap sets, write of one clears; the set wins
            if (wrap)
                flag_q <= 1'b1;
            else if (wr_flag && wr_byte[0])
                flag_q <= 1'b0;
            if (wr_irqen)
                irq_en_q <= wr_byte[0];
            // inverting amplifier, independent of sleep
            osc_out_q    <= !pin_bus.sync[PIN_OSC];
            base_valid_q <= known_q && (mode != MODE_ASYNC);
            base_q       <= (known_q && mode != MODE_ASYNC) ? count_q
                                                            : CNT_ZERO;
        end
    end

    assign OSC_OUT_O          = osc_out_q;
    assign OSC_OUT_OE_O       = osc_en;
    assign COUNT_O            = base_q;
    assign COUNT_BASE_VALID_O = base_valid_q;
    assign OVF_IRQ_O          = flag_q && irq_en_q;
    assign WAKE_O             = flag_q && irq_en_q && SLEEP_I;

    // -----------------------------------------------------------------
    // bus write handshake
    // -----------------------------------------------------------------
    // address and data may arrive in either order
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            wr_state_q  <= WR_IDLE;
            aw_got_q    <= 1'b0;
            w_got_q     <= 1'b0;
            awidx_q     <= 6'h00;
            wbyte_q     <= 8'h00;
            wlane_q     <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end
        else if (CE_I)
        begin
            if (aw_hs)
                awidx_q <= S_AXI_AWADDR[ADDR_W-1:2];
            if (w_hs)
            begin
                wbyte_q <= S_AXI_WDATA[7:0];
                wlane_q <= S_AXI_WSTRB[0];
            end
            case (wr_state_q)
                WR_IDLE:
                begin
                    aw_got_q <= aw_have && !do_wr;
                    w_got_q  <= w_have && !do_wr;
                    if (do_wr)
                    begin
                        wr_state_q  <= WR_RESP;
                        S_AXI_BRESP <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                WR_RESP:
                    if (S_AXI_BREADY)
                        wr_state_q <= WR_IDLE;
                default:
                    wr_state_q <= WR_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // bus read path
    // -----------------------------------------------------------------
    wire [5:0] rd_idx = S_AXI_ARADDR[ADDR_W-1:2];
    wire [CNT_W-1:0] rd_cnt = known_q ? count_q : CNT_ZERO;
    wire ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
    logic [DATA_W-1:0] rd_val;
    logic              rd_ok;

    // count lives in this clock domain, so a read never tears
    always_comb
    begin
        rd_val = '0;
        rd_ok  = 1'b1;
        case (rd_idx)
            CNT_LO_IDX: rd_val[7:0]        = rd_cnt[7:0];
            CNT_HI_IDX: rd_val[7:0]        = rd_cnt[15:8];
            CTRL_IDX:   rd_val[CTRL_W-1:0] = ctrl_q;
            FLAG_IDX:   rd_val[0]          = flag_q;
            IRQEN_IDX:  rd_val[0]          = irq_en_q;
            default:    rd_ok              = 1'b0;
        endcase
    end

    assign S_AXI_ARREADY = !rvalid_q;
    assign S_AXI_RVALID  = rvalid_q;
    assign S_AXI_RDATA   = rdata_q;
    assign S_AXI_RRESP   = rresp_q;

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end
        else if (CE_I)
        begin
            if (ar_hs)
            begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_val;
                rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (S_AXI_RREADY)
                rvalid_q <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    AST_TIMER_STEP: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        CE_I && mode == MODE_TIMER && run_en && !SLEEP_I && ps_sel == 2'b00
        && !wr_cnt && !evt_clr |=> count_q == $past(count_q) + 16'h0001)
        else $error("timer mode did not advance every cycle");

    AST_SLEEP_HOLD: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        CE_I && mode == MODE_SYNC && SLEEP_I && !wr_cnt && !evt_clr
        |=> count_q == $past(count_q))
        else $error("synchronised count moved during sleep");

    AST_BASE_ASYNC: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        CE_I && mode == MODE_ASYNC |=> !COUNT_BASE_VALID_O)
        else $error("time base offered in asynchronous mode");

    AST_EVT_CLEAR: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        CE_I && evt_clr && !wr_cnt |=> count_q == CNT_ZERO)
        else $error("special event did not clear count");

    AST_EVT_NOFLAG: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        CE_I && evt_clr && !flag_q |=> !flag_q)
        else $error("special event set the overflow flag");

    AST_WRITE_WINS: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        CE_I && evt_clr && wr_lo |=> count_q[7:0] == $past(wr_byte))
        else $error("clear overrode count write");

    AST_CTRL_RESET: assert property (@(posedge CLK_I)
        $fell(SYS_RST_I) |-> ctrl_q == CTRL_RST && !run_en)
        else $error("control not cleared by power-on reset");

    AST_PRE_CLEAR: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        CE_I && wr_cnt |=> pre_q == PRE_ZERO)
        else $error("count write left prescaler running");

    AST_WRAP_FLAG: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        CE_I && wrap && !wr_cnt && !evt_clr
        |=> flag_q && count_q == CNT_ZERO)
        else $error("wrap did not set flag");

    AST_RUN_HOLD: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        CE_I && known_q && !run_en && !wr_cnt && !evt_clr ##1 !run_en
        |-> count_q == $past(count_q))
        else $error("count moved while stopped");

endmodule // tcn_timer

`default_nettype wire

// ==== tcn_ext_clk_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// far-side clock source; both pins idle high, each pulse falls then rises
module tcn_ext_clk_model
(
    output var logic ext_o,
    output var logic osc_o
);
    // idle level until a burst is asked for
    initial
    begin
        ext_o = 1'b1;
        osc_o = 1'b1;
    end

    // phase unrelated to the bench clock, still between bursts
    task automatic pulse(input logic sel, input int n);
        repeat (n)
        begin
            #173;
            if (sel) osc_o = 1'b0; else ext_o = 1'b0;
            #173;
            if (sel) osc_o = 1'b1; else ext_o = 1'b1;
        end
    endtask
endmodule // tcn_ext_clk_model

`default_nettype wire

// ==== tcn_timer_tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module tcn_timer_tb;
    import tcn_pkg::*;
    logic clk = 0, rst = 1, warm = 0, slp = 0, t1 = 0, t2 = 0;
    logic ext, osc, oo, ooe, bv_o, irq, wake, awrdy, wrdy, bvld, arrdy, rvld;
    logic [3:0]  m1 = 0, m2 = 0;
    logic [15:0] cnt;
    logic [7:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, rdata;
    logic [1:0]  bresp, rresp;
    logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    int err_total = 0, n_checks = 0;

    // 20 MHz bench clock
    always #25 clk = ~clk;

    tcn_ext_clk_model u_tcn_ext_clk_model (.ext_o(ext), .osc_o(osc));
    tcn_timer u_tcn_timer (.CLK_I(clk), .SYS_RST_I(rst), .WARM_RST_I(warm),
        .CE_I(1'b1), .SLEEP_I(slp), .EXT_CNT_I(ext), .OSC_IN_I(osc),
        .OSC_OUT_O(oo), .OSC_OUT_OE_O(ooe), .CMP1_MODE_I(m1),
        .CMP1_TRIG_I(t1), .CMP2_MODE_I(m2), .CMP2_TRIG_I(t2),
        .COUNT_O(cnt), .COUNT_BASE_VALID_O(bv_o), .OVF_IRQ_O(irq),
        .WAKE_O(wake), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvld), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvld), .S_AXI_RREADY(rr));

    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // address and data offered together, each released when taken
    task automatic wr(input logic [5:0] i, input logic [31:0] d);
        @(posedge clk);
        awa <= {i, 2'b00};
        wd  <= d;
        awv <= 1;
        wv  <= 1;
        br  <= 1;
        do
        begin
            @(posedge clk);
            if (awv && awrdy) awv <= 0;
            if (wv && wrdy) wv <= 0;
        end while (!bvld);
        br <= 0;
    endtask

    task automatic rc(input logic [5:0] i, input logic [31:0] e,
                      input logic [1:0] re);
        @(posedge clk);
        ara <= {i, 2'b00};
        arv <= 1;
        rr  <= 1;
        do
        begin
            @(posedge clk);
            if (arv && arrdy) arv <= 0;
        end while (!rvld);
        rr <= 0;
        chk(rdata, e);
        chk(rresp, re);
    endtask

    task automatic sc_scale;
        logic [15:0] c0;
        wr(CNT_LO_IDX, 0);
        for (int k = 0; k < 4; k++)
        begin
            wr(CTRL_IDX, {k[1:0], 4'h5});
            repeat (4) @(posedge clk);
            c0 = cnt;
            repeat (16) @(posedge clk);
            chk(cnt - c0, 16 >> k);
        end
        wr(CTRL_IDX, 0);
        repeat (2) @(posedge clk);
        c0 = cnt;
        repeat (8) @(posedge clk);
        chk(cnt, c0);
    endtask

    task automatic trig(input logic u);
        @(posedge clk);
        if (u) t2 <= 1; else t1 <= 1;
        @(posedge clk);
        t1 <= 0;
        t2 <= 0;
        repeat (3) @(posedge clk);
    endtask

    // count write and special event clear land on the same edge
    task automatic sc_race;
        fork
            wr(CNT_LO_IDX, 32'h5a);
            begin
                @(posedge clk);
                t1 <= 1;
                @(posedge clk);
                t1 <= 0;
            end
        join
        rc(CNT_LO_IDX, 32'h5a, RESP_OKAY);
    endtask

    // one external-clock run: optional pre-burst, clean restart, burst
    task automatic ext1(input logic [5:0] c, input logic s, input logic z,
                        input int pre, input int n, input logic [7:0] e,
                        input logic v);
        wr(CTRL_IDX, c);
        u_tcn_ext_clk_model.pulse(s, pre);
        wr(CTRL_IDX, 0);
        wr(CNT_LO_IDX, 0);
        wr(CNT_HI_IDX, 0);
        wr(CTRL_IDX, c);
        slp <= z;
        u_tcn_ext_clk_model.pulse(s, n);
        repeat (6) @(posedge clk);
        chk(bv_o, v);
        chk(ooe, c[OSCEN_BIT]);
        chk(oo, !osc);
        wr(CTRL_IDX, 0);
        slp <= 0;
        rc(CNT_LO_IDX, e, RESP_OKAY);
    endtask

    // main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 0;
        rc(CTRL_IDX, 0, RESP_OKAY);
        rc(6'h00, 0, RESP_SLVERR);
        m1 <= SPECIAL_EVT_MODE;
        trig(0);
        rc(CNT_LO_IDX, 0, RESP_OKAY);
        wr(CTRL_IDX, 32'h31);
        warm <= 1;
        @(posedge clk);
        warm <= 0;
        rc(CTRL_IDX, 32'h31, RESP_OKAY);
        wr(CTRL_IDX, 0);
        sc_scale;
        wr(CNT_LO_IDX, 32'hf0);
        wr(CNT_HI_IDX, 32'hfe);
        wr(IRQEN_IDX, 1);
        wr(CTRL_IDX, 1);
        repeat (300) @(posedge clk);
        wr(CTRL_IDX, 0);
        rc(CNT_HI_IDX, 0, RESP_OKAY);
        rc(FLAG_IDX, 1, RESP_OKAY);
        chk(irq, 1);
        slp <= 1;
        @(posedge clk);
        chk(wake, 1);
        slp <= 0;
        wr(FLAG_IDX, 1);
        @(posedge clk);
        chk(irq, 0);
        wr(CNT_HI_IDX, 32'h12);
        m1 <= SPECIAL_EVT_MODE;
        m2 <= 4'ha;
        wr(CTRL_IDX, 1);
        trig(1);
        chk(cnt[15:8], 8'h12);
        trig(0);
        chk(cnt[15:8], 0);
        m2 <= SPECIAL_EVT_MODE;
        repeat (30) @(posedge clk);
        trig(1);
        chk(cnt < 16'h0008, 1);
        wr(CTRL_IDX, 0);
        sc_race;
        rc(FLAG_IDX, 0, RESP_OKAY);
        ext1(6'h07, 0, 0, 0, 5, 8'h05, 0);
        ext1(6'h37, 0, 0, 4, 7, 8'h00, 0);
        ext1(6'h0f, 1, 1, 0, 5, 8'h05, 0);
        ext1(6'h03, 0, 1, 0, 5, 8'h00, 1);
        ext1(6'h03, 0, 0, 0, 5, 8'h05, 1);
        rst <= 1;
        @(posedge clk);
        rst <= 0;
        rc(CNT_LO_IDX, 32'h05, RESP_OKAY);
        rc(CTRL_IDX, 0, RESP_OKAY);
        summarize;
    end

    // watchdog well beyond the expected run
    initial
    begin
        #3000000;
        err_total++;
        summarize;
    end
endmodule // tcn_timer_tb

`default_nettype wire
